// ==== src/fault_flags_cfg.svh ====
/*
 * Offsets, field positions, implemented-bit masks and reset values of the
 * four event flag registers.
 * Assumes it is included by bare name, once or more, before use.
 */
`ifndef FAULT_FLAGS_CFG_SVH
`define FAULT_FLAGS_CFG_SVH

`define FLAG_REG_COUNT 4
`define FLAG_DATA_W 8

// Register offsets on the register bus.
`define SYS_FAULT_ADDR 8'h1B
`define SYS_INT_ADDR 8'h1C
`define CTRL_FAULT_ADDR 8'h1D
`define CTRL_INT_ADDR 8'h1E

// Storage index of each register.
`define SYS_FAULT_IDX 2'h0
`define SYS_INT_IDX 2'h1
`define CTRL_FAULT_IDX 2'h2
`define CTRL_INT_IDX 2'h3

// Bits that hold a flag; all others read as zero.
`define SYS_FAULT_MASK 8'hF1
`define SYS_INT_MASK 8'hEF
`define CTRL_FAULT_MASK 8'hC9
`define CTRL_INT_MASK 8'h08
`define FLAG_RESET 8'h00

// System fault register fields.
`define REF_FAULT_TWO_BIT 7
`define REF_FAULT_ONE_BIT 6
`define IO_OV_BIT 5
`define IO_UV_BIT 4
`define FUSE_ERR_BIT 0

// System interrupt register fields.
`define REF_WARN_HIGH_BIT 7
`define REF_WARN_LOW_BIT 6
`define WAKE_CAUSE_BIT 5
`define SYNC_FAULT_BIT 3
`define WAKE_PIN_BIT 2
`define VOUT_CFG_BIT 1
`define SUPV_CFG_BIT 0

// Controller fault and interrupt register fields.
`define HARD_RESET_BIT 7
`define SOFT_RESET_BIT 6
`define WWD_FAULT_BIT 3
`define INIT_ERR_BIT 0
`define WWD_MISS_BIT 3

`endif

// ==== src/fault_flags_pkg.sv ====
/*
 * Types shared by the event flag register bank.
 * Assumes fault_flags_cfg.svh sits on the include path.
 */
`include "fault_flags_cfg.svh"

package fault_flags_pkg;

    typedef logic [`FLAG_DATA_W-1:0] flag_byte_t;
    typedef logic [`FLAG_REG_COUNT-1:0][`FLAG_DATA_W-1:0] flag_bank_t;
    typedef logic [1:0] reg_index_t;

    typedef struct packed {
        flag_bank_t flags;
        flag_byte_t rdata;
        logic rvalid;
        logic sys_pulse;
        logic ctrl_pulse;
    } flag_state_s;

endpackage

// ==== src/fault_flag_bank.sv ====
/*
 * Event flag bank: system fault, system interrupt, controller fault and
 * controller interrupt flags, sticky until written with one.
 * Assumes a serial front end outside that turns frames into single-cycle
 * register reads and writes on the clk domain, and detectors that drive
 * their event inputs synchronously to clk.
 */
//
// What this block does
// - Second reference fault sets system fault bit 7, held until cleared.
// - First reference fault sets system fault bit 6, held until cleared.
// - Fuse double-bit error sets system fault bit 0; bits 3:1 read zero.
// - Reference high warning sets interrupt bit 7, low warning bit 6.
// - Wake cause bit 5 reads zero after a power-on wake-up.
// - Wake cause bit 5 reads one after enable-pin wake-up; write one clears.
// - External clock sync failure sets interrupt bit 3, sticky.
// - Output voltage configuration fault sets interrupt bit 1.
// - Supervision configuration fault sets interrupt bit 0.
// - Watchdog fault sets controller bit 3; bits 5:4 and 2:1 hold nothing.
// - Init timer error sets controller fault bit 0.
// - Missed watchdog trigger sets controller interrupt bit 3; others zero.
// - Flags read one after an event; only a written one clears.
// - Written zeros change nothing; all flags reset to zero.
// - A newly set flag pulses the matching global system or controller bit.
// - Clearing detailed flags never touches the global bits, and vice versa.
`timescale 1ns/1ps
`default_nettype none
`include "fault_flags_cfg.svh"

module fault_flag_bank #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [`FLAG_DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [`FLAG_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic reference_fault_two,
    input wire logic reference_fault_one,
    input wire logic io_supply_overvoltage,
    input wire logic io_supply_undervoltage,
    input wire logic fuse_double_bit_error,
    input wire logic reference_warning_high,
    input wire logic reference_warning_low,
    input wire logic wake_cause,
    input wire logic sync_fault,
    input wire logic wake_pin_interrupt,
    input wire logic output_voltage_config_fault,
    input wire logic supervision_config_fault,
    input wire logic hard_reset_event,
    input wire logic soft_reset_event,
    input wire logic window_watchdog_fault,
    input wire logic init_timer_error,
    input wire logic watchdog_missed_trigger,
    output logic sys_global_set,
    output logic ctrl_global_set
);

    // Offsets are eight bits wide; a narrower address cannot reach them.
    if (ADDR_W < 8) begin : g_addr_check
        $error("fault_flag_bank: ADDR_W must be at least 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoding shared by the read and write paths.

    function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
        logic [2:0] r;
        r = 3'h0;
        if ((a >> 8) == '0) begin
            case (a[7:0])
                `SYS_FAULT_ADDR: r = {1'b1, `SYS_FAULT_IDX};
                `SYS_INT_ADDR: r = {1'b1, `SYS_INT_IDX};
                `CTRL_FAULT_ADDR: r = {1'b1, `CTRL_FAULT_IDX};
                `CTRL_INT_ADDR: r = {1'b1, `CTRL_INT_IDX};
                default: r = 3'h0;
            endcase
        end
        return r;
    endfunction

    function automatic fault_flags_pkg::flag_byte_t mask_of(
        input fault_flags_pkg::reg_index_t i);
        fault_flags_pkg::flag_byte_t m;
        m = `CTRL_INT_MASK;
        case (i)
            `SYS_FAULT_IDX: m = `SYS_FAULT_MASK;
            `SYS_INT_IDX: m = `SYS_INT_MASK;
            `CTRL_FAULT_IDX: m = `CTRL_FAULT_MASK;
            default: m = `CTRL_INT_MASK;
        endcase
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event vectors, one byte per register, in field order.

    fault_flags_pkg::flag_state_s q;
    fault_flags_pkg::flag_state_s next_q;
    fault_flags_pkg::flag_bank_t ev;
    fault_flags_pkg::flag_bank_t clr;
    fault_flags_pkg::flag_bank_t rose;
    logic [2:0] wsel;
    logic [2:0] rsel;

    always_comb begin
        ev = '0;
        ev[`SYS_FAULT_IDX][`REF_FAULT_TWO_BIT] = reference_fault_two;
        ev[`SYS_FAULT_IDX][`REF_FAULT_ONE_BIT] = reference_fault_one;
        ev[`SYS_FAULT_IDX][`IO_OV_BIT] = io_supply_overvoltage;
        ev[`SYS_FAULT_IDX][`IO_UV_BIT] = io_supply_undervoltage;
        ev[`SYS_FAULT_IDX][`FUSE_ERR_BIT] = fuse_double_bit_error;
        ev[`SYS_INT_IDX][`REF_WARN_HIGH_BIT] = reference_warning_high;
        ev[`SYS_INT_IDX][`REF_WARN_LOW_BIT] = reference_warning_low;
        // A power-on wake leaves the bit at its reset value of zero.
        ev[`SYS_INT_IDX][`WAKE_CAUSE_BIT] = wake_cause;
        ev[`SYS_INT_IDX][`SYNC_FAULT_BIT] = sync_fault;
        ev[`SYS_INT_IDX][`WAKE_PIN_BIT] = wake_pin_interrupt;
        ev[`SYS_INT_IDX][`VOUT_CFG_BIT] = output_voltage_config_fault;
        ev[`SYS_INT_IDX][`SUPV_CFG_BIT] = supervision_config_fault;
        ev[`CTRL_FAULT_IDX][`HARD_RESET_BIT] = hard_reset_event;
        ev[`CTRL_FAULT_IDX][`SOFT_RESET_BIT] = soft_reset_event;
        ev[`CTRL_FAULT_IDX][`WWD_FAULT_BIT] = window_watchdog_fault;
        ev[`CTRL_FAULT_IDX][`INIT_ERR_BIT] = init_timer_error;
        ev[`CTRL_INT_IDX][`WWD_MISS_BIT] = watchdog_missed_trigger;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    assign wsel = decode(reg_addr);
    assign rsel = decode(reg_addr);

    always_comb begin
        next_q = q;
        next_q.rvalid = 1'b0;
        next_q.sys_pulse = 1'b0;
        next_q.ctrl_pulse = 1'b0;
        clr = '0;
        rose = '0;
        for (int i = 0; i < `FLAG_REG_COUNT; i++) begin
            if (reg_wr && wsel[2] && (wsel[1:0] == i[1:0])) begin
                clr[i] = reg_wdata;
            end
            // The set term is ORed after the clear, so an event that lands
            // in the same cycle as its clear is kept. Unused bits, even
            // the clearable pair in the controller fault register, have no
            // source and are masked to zero.
            next_q.flags[i] = ((q.flags[i] & ~clr[i]) | ev[i]) & mask_of(i[1:0]);
            rose[i] = next_q.flags[i] & ~q.flags[i];
        end
        // Only a 0-to-1 change of a flag pulses the global bit, so a held
        // event level produces one pulse, not a stream.
        next_q.sys_pulse = (|rose[`SYS_FAULT_IDX]) | (|rose[`SYS_INT_IDX]);
        next_q.ctrl_pulse = (|rose[`CTRL_FAULT_IDX]) | (|rose[`CTRL_INT_IDX]);
        if (reg_rd) begin
            next_q.rvalid = 1'b1;
            // A read shows the value before any write or event of the same
            // cycle; unmapped addresses answer zero.
            next_q.rdata = rsel[2] ? q.flags[rsel[1:0]] : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign reg_rdata = q.rdata;
    assign reg_rvalid = q.rvalid;
    // There is no path from the global register back into these flags, and
    // nothing here clears the global bits; they only receive set pulses.
    assign sys_global_set = q.sys_pulse;
    assign ctrl_global_set = q.ctrl_pulse;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    logic wr_sys_fault;
    logic wr_sys_int;
    logic wr_ctrl_fault;
    assign wr_sys_fault = reg_wr && (reg_addr == ADDR_W'(`SYS_FAULT_ADDR));
    assign wr_sys_int = reg_wr && (reg_addr == ADDR_W'(`SYS_INT_ADDR));
    assign wr_ctrl_fault = reg_wr && (reg_addr == ADDR_W'(`CTRL_FAULT_ADDR));

    property p_ref_two_set;
        @(posedge clk) disable iff (rst)
        reference_fault_two |=> q.flags[0][7];
    endproperty
    a_ref_two_set: assert property (p_ref_two_set)
        else $error("reference fault two flag not set");

    property p_ref_one_hold;
        @(posedge clk) disable iff (rst)
        (q.flags[0][6] && !(wr_sys_fault && reg_wdata[6])) |=> q.flags[0][6];
    endproperty
    a_ref_one_hold: assert property (p_ref_one_hold)
        else $error("reference fault one flag lost without a clear");

    property p_io_set;
        @(posedge clk) disable iff (rst)
        (io_supply_overvoltage && io_supply_undervoltage) |=> (q.flags[0][5:4] == 2'h3);
    endproperty
    a_io_set: assert property (p_io_set)
        else $error("IO supply flags not set");

    property p_sys_unused;
        @(posedge clk) disable iff (rst)
        reg_wr |=> (q.flags[0][3:1] == 3'h0) && (q.flags[1][4] == 1'b0);
    endproperty
    a_sys_unused: assert property (p_sys_unused)
        else $error("unused system bit became set");

    property p_warn_set;
        @(posedge clk) disable iff (rst)
        (reference_warning_high && wr_sys_int && reg_wdata[7]) |=> q.flags[1][7];
    endproperty
    a_warn_set: assert property (p_warn_set)
        else $error("warning event lost against a same-cycle clear");

    property p_wake_clear;
        @(posedge clk) disable iff (rst)
        (q.flags[1][5] && wr_sys_int && reg_wdata[5] && !wake_cause) |=> !q.flags[1][5];
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("wake cause not cleared by a written one");

    property p_ctrl_unused;
        @(posedge clk) disable iff (rst)
        1'b1 |-> (q.flags[2][5:4] == 2'h0) && (q.flags[2][2:1] == 2'h0) &&
                 (q.flags[3][7:4] == 4'h0) && (q.flags[3][2:0] == 3'h0);
    endproperty
    a_ctrl_unused: assert property (p_ctrl_unused)
        else $error("unused controller bit became set");

    property p_zero_write;
        @(posedge clk) disable iff (rst)
        (wr_ctrl_fault && reg_wdata == 8'h00 && !hard_reset_event && !soft_reset_event &&
         !window_watchdog_fault && !init_timer_error) |=> $stable(q.flags[2]);
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("writing zero changed a controller flag");

    property p_sys_pulse;
        @(posedge clk) disable iff (rst)
        ($rose(q.flags[0][0]) || $rose(q.flags[1][3])) |-> sys_global_set;
    endproperty
    a_sys_pulse: assert property (p_sys_pulse)
        else $error("system global set pulse missing");

    property p_ctrl_pulse_once;
        @(posedge clk) disable iff (rst)
        ctrl_global_set |=> !ctrl_global_set || $changed(q.flags[2]) || $changed(q.flags[3]);
    endproperty
    a_ctrl_pulse_once: assert property (p_ctrl_pulse_once)
        else $error("controller global set pulse held without a new flag");

    property p_readback;
        @(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == ADDR_W'(`SYS_FAULT_ADDR)) |=>
            reg_rvalid && (reg_rdata == $past(q.flags[0]));
    endproperty
    a_readback: assert property (p_readback)
        else $error("read data does not match the flag register");

    property p_sync_set;
        @(posedge clk) disable iff (rst)
        sync_fault |=> q.flags[`SYS_INT_IDX][`SYNC_FAULT_BIT];
    endproperty
    a_sync_set: assert property (p_sync_set)
        else $error("clock sync fault flag not set");

    property p_vout_cfg_set;
        @(posedge clk) disable iff (rst)
        output_voltage_config_fault |=> q.flags[`SYS_INT_IDX][`VOUT_CFG_BIT];
    endproperty
    a_vout_cfg_set: assert property (p_vout_cfg_set)
        else $error("output voltage configuration flag not set");

    property p_supv_cfg_set;
        @(posedge clk) disable iff (rst)
        supervision_config_fault |=> q.flags[`SYS_INT_IDX][`SUPV_CFG_BIT];
    endproperty
    a_supv_cfg_set: assert property (p_supv_cfg_set)
        else $error("supervision configuration flag not set");

    property p_hard_set;
        @(posedge clk) disable iff (rst)
        hard_reset_event |=> q.flags[`CTRL_FAULT_IDX][`HARD_RESET_BIT];
    endproperty
    a_hard_set: assert property (p_hard_set)
        else $error("hard reset flag not set");

    property p_soft_set;
        @(posedge clk) disable iff (rst)
        soft_reset_event |=> q.flags[`CTRL_FAULT_IDX][`SOFT_RESET_BIT];
    endproperty
    a_soft_set: assert property (p_soft_set)
        else $error("soft reset flag not set");

    property p_init_set;
        @(posedge clk) disable iff (rst)
        init_timer_error |=> q.flags[`CTRL_FAULT_IDX][`INIT_ERR_BIT];
    endproperty
    a_init_set: assert property (p_init_set)
        else $error("init timer flag not set");

    property p_miss_set;
        @(posedge clk) disable iff (rst)
        watchdog_missed_trigger |=> q.flags[`CTRL_INT_IDX][`WWD_MISS_BIT];
    endproperty
    a_miss_set: assert property (p_miss_set)
        else $error("missed trigger flag not set");

    property p_wake_set;
        @(posedge clk) disable iff (rst)
        wake_cause |=> q.flags[`SYS_INT_IDX][`WAKE_CAUSE_BIT];
    endproperty
    a_wake_set: assert property (p_wake_set)
        else $error("wake cause flag not set");

    property p_pin_set;
        @(posedge clk) disable iff (rst)
        wake_pin_interrupt |=> q.flags[`SYS_INT_IDX][`WAKE_PIN_BIT];
    endproperty
    a_pin_set: assert property (p_pin_set)
        else $error("enable interrupt flag not set");

    property p_clear_no_pulse;
        @(posedge clk) disable iff (rst)
        (reg_wr && (ev == '0)) |=> !sys_global_set && !ctrl_global_set;
    endproperty
    a_clear_no_pulse: assert property (p_clear_no_pulse)
        else $error("a clear produced a global set pulse");

    property p_rvalid_once;
        @(posedge clk) disable iff (rst)
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid_once: assert property (p_rvalid_once)
        else $error("read valid raised without a read");

endmodule // fault_flag_bank

`default_nettype wire

// ==== verification/mcu_host_model.sv ====
/*
 * Microcontroller model: issues single-cycle register reads and writes.
 * Assumes the flag bank samples its strobes on the rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none

module mcu_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // Ones in d clear flags; released lines show the inverse so stale values never match.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        d = reg_rdata;
        v = reg_rvalid;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // mcu_host_model

`default_nettype wire

// ==== verification/fault_flag_bank_tb.sv ====
/*
 * Self-checking bench for the event flag bank with an integer flag model.
 * Assumes fault_flags_cfg.svh on the include path and mcu_host_model compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fault_flags_cfg.svh"

module fault_flag_bank_tb;
    logic clk;
    logic rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid, sys_global_set, ctrl_global_set;
    logic [16:0] ev = '0;
    int mismatches = 0, num_checks = 0, cycles = 0, seed = 60655;
    int exp_f[5] = '{0, 0, 0, 0, 0};
    // Event k sets register pos[k]/8, bit pos[k]%8.
    int pos[17] = '{7, 6, 5, 4, 0, 15, 14, 13, 11, 10, 9, 8, 23, 22, 19, 16, 27};
    logic [7:0] addrs[5] = '{`SYS_FAULT_ADDR, `SYS_INT_ADDR, `CTRL_FAULT_ADDR,
        `CTRL_INT_ADDR, 8'h1A};

    fault_flag_bank fault_flag_bank_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reference_fault_two(ev[0]), .reference_fault_one(ev[1]),
        .io_supply_overvoltage(ev[2]), .io_supply_undervoltage(ev[3]),
        .fuse_double_bit_error(ev[4]), .reference_warning_high(ev[5]),
        .reference_warning_low(ev[6]), .wake_cause(ev[7]), .sync_fault(ev[8]),
        .wake_pin_interrupt(ev[9]), .output_voltage_config_fault(ev[10]),
        .supervision_config_fault(ev[11]), .hard_reset_event(ev[12]),
        .soft_reset_event(ev[13]), .window_watchdog_fault(ev[14]),
        .init_timer_error(ev[15]), .watchdog_missed_trigger(ev[16]),
        .sys_global_set(sys_global_set), .ctrl_global_set(ctrl_global_set));

    mcu_host_model mcu_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pulse(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t strobe %b expected %b", $time, got, exp);
        end
    endtask

    task automatic fire(input logic [16:0] v);
        logic es, ec;
        int r;
        es = 1'b0;
        ec = 1'b0;
        for (int k = 0; k < 17; k++) begin
            if (v[k]) begin
                r = pos[k] / 8;
                if (exp_f[r][pos[k] % 8] == 1'b0) begin
                    if (r < 2) es = 1'b1;
                    else ec = 1'b1;
                end
                exp_f[r] |= 1 << (pos[k] % 8);
            end
        end
        @(posedge clk);
        #1;
        ev = v;
        @(posedge clk);
        #1;
        ev = '0;
        check_pulse(sys_global_set, es);
        check_pulse(ctrl_global_set, ec);
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        mcu_host_model_i.write_reg(addrs[i], d);
        exp_f[i] &= ~int'(d);
        check_pulse(sys_global_set, 1'b0);
        check_pulse(ctrl_global_set, 1'b0);
    endtask

    task automatic rd_chk(input int i);
        logic [7:0] d;
        logic v;
        mcu_host_model_i.read_reg(addrs[i], d, v);
        check_pulse(v, 1'b1);
        check_data(d, exp_f[i][7:0]);
    endtask

    initial begin
        int r, b;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(i);
        for (int k = 0; k < 17; k++) begin
            r = pos[k] / 8;
            b = pos[k] % 8;
            fire(17'(1) << k);
            rd_chk(r);
            fire(17'(1) << k);
            wr(r, ~(8'h01 << b));
            rd_chk(r);
            wr(r, 8'h01 << b);
            rd_chk(r);
        end
        fire('1);
        for (int i = 0; i < 5; i++) rd_chk(i);
        for (int i = 0; i < 5; i++) wr(i, 8'hFF);
        for (int i = 0; i < 5; i++) rd_chk(i);
        // An event and a clear of the same flag in one cycle: the event wins.
        fire(17'(1) << 5);
        fork
            fire(17'(1) << 5);
            mcu_host_model_i.write_reg(addrs[1], 8'hFF);
        join
        rd_chk(1);
        wr(1, 8'h80);
        rd_chk(1);
        fire(17'h0F000);
        wr(2, 8'h00);
        rd_chk(2);
        wr(2, 8'hFF);
        rd_chk(2);
        repeat (30) begin
            fire(17'($random(seed)));
            wr($unsigned($random(seed)) % 5, 8'($random(seed)));
            for (int i = 0; i < 5; i++) rd_chk(i);
        end
        // A reset in mid-run must drop every flag that is set.
        fire('1);
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        check_pulse(sys_global_set, 1'b0);
        check_pulse(ctrl_global_set, 1'b0);
        for (int i = 0; i < 5; i++) begin
            exp_f[i] = 0;
            rd_chk(i);
        end
        stop_test();
    end
endmodule // fault_flag_bank_tb

`default_nettype wire
